// ---- inc/sitp_pkg.sv ----
package sitp_pkg;

   // Upper five bits of the target address
   localparam logic [4:0] ADDR_FIXED    = 5'h04;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [7:0] REG_RESET     = 8'h00;

   // Watchdog timeout, derived from the clock rate
   localparam int unsigned CLK_HZ      = 40_000_000;
   localparam int unsigned MS_PER_S    = 1000;
   localparam int unsigned LOCKUP_MS   = 50;
   localparam int unsigned LOCKUP_CYC  = CLK_HZ / MS_PER_S * LOCKUP_MS;
   localparam int          WD_W        = 22;

   localparam logic [1:0] BUF_FULL = 2'h2;

   typedef enum logic [3:0] {
      PH_IDLE     = 4'h0,
      PH_ADDR     = 4'h1,
      PH_ADDR_ACK = 4'h3,
      PH_REG      = 4'h2,
      PH_REG_ACK  = 4'h6,
      PH_DATA     = 4'h7,
      PH_DATA_ACK = 4'h5,
      PH_IGNORE   = 4'h4,
      PH_RD_BYTE  = 4'hB,
      PH_RD_ACK   = 4'hA
   } sitp_phase_t;

   typedef struct packed {
      logic [7:0] regAddr;
      logic [7:0] data;
   } sitp_wr_word_t;

   typedef struct packed {
      logic             sclMeta;
      logic             sclSync;
      logic             sclLast;
      logic             sdaMeta;
      logic             sdaSync;
      logic             sdaLast;
      logic [1:0]       strapMeta;
      logic [1:0]       strapSync;
      sitp_phase_t      phase;
      logic [3:0]       bitCnt;
      logic [7:0]       rxShift;
      logic [7:0]       txShift;
      logic             hostAck;
      logic             sclFell;
      logic [7:0]       startAddr;
      logic [7:0]       rdPtr;
      logic             sdaOe;
      logic [WD_W-1:0]  wdCnt;
   } sitp_state_t;

   typedef struct packed {
      sitp_wr_word_t [1:0] slot;
      logic                wrIdx;
      logic                rdIdx;
      logic [1:0]          count;
   } sitp_buf_t;

endpackage

// ---- rtl/sitp_wr_buf.sv ----
`timescale 1ns/1ps
`default_nettype none

module sitp_wr_buf
   import sitp_pkg::*;
(
   input  wire logic          clk,
   input  wire logic          sys_rst,
   input  wire logic          inValid,
   output logic               inReady,
   input  wire sitp_wr_word_t inWord,
   output logic               outValid,
   input  wire logic          outReady,
   output sitp_wr_word_t      outWord
);

   sitp_buf_t q;
   sitp_buf_t d;
   logic      doPush;
   logic      doPop;

   assign inReady  = (q.count != BUF_FULL);
   assign outValid = (q.count != 2'h0);
   assign outWord  = q.slot[q.rdIdx];
   assign doPush   = inValid & inReady;
   assign doPop    = outValid & outReady;

   always_comb begin
      d = q;
      if (doPush) begin
         d.slot[q.wrIdx] = inWord;
         d.wrIdx = ~q.wrIdx;
      end
      if (doPop) begin
         d.rdIdx = ~q.rdIdx;
      end
      if (doPush && !doPop) begin
         d.count = q.count + 2'h1;
      end else if (doPop && !doPush) begin
         d.count = q.count - 2'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

endmodule

`default_nettype wire

// ---- rtl/sitp_target.sv ----
`timescale 1ns/1ps
`default_nettype none

module sitp_target
   import sitp_pkg::*;
#(
   parameter int unsigned LOCKUP_CYCLES = LOCKUP_CYC
)
(
   input  wire logic          clk,
   input  wire logic          sys_rst,
   input  wire logic          serialClockPin,
   input  wire logic          serialDataPinIn,
   output logic               serialDataPinOut,
   output logic               serialDataPinOe,
   input  wire logic          addressBit0StrapPin,
   input  wire logic          addressBit1StrapPin,
   output logic [7:0]         rdAddr,
   input  wire logic [7:0]    rdData,
   output logic               wrValid,
   input  wire logic          wrReady,
   output sitp_wr_word_t      wrWord,
   output logic               busBusy
);

   sitp_state_t   q;
   sitp_state_t   d;
   logic          sclRise;
   logic          sclFall;
   logic          sclHigh;
   logic          sdaRise;
   logic          sdaFall;
   logic          startDet;
   logic          stopDet;
   logic          byteDone;
   logic          addrMatch;
   logic          wdFire;
   logic          pushValid;
   logic          pushReady;
   sitp_wr_word_t pushWord;
   logic [6:0]    ownAddr;

   // Edges are taken between the second and third stage only
   assign sclRise = q.sclSync & ~q.sclLast;
   assign sclFall = ~q.sclSync & q.sclLast;
   assign sclHigh = q.sclSync & q.sclLast;
   assign sdaRise = q.sdaSync & ~q.sdaLast;
   assign sdaFall = ~q.sdaSync & q.sdaLast;

   assign startDet = sdaFall & sclHigh;
   assign stopDet  = sdaRise & sclHigh;

   assign byteDone  = (q.bitCnt == BITS_PER_BYTE);
   assign ownAddr   = {ADDR_FIXED, q.strapSync[1], q.strapSync[0]};
   assign addrMatch = (q.rxShift[7:1] == ownAddr);

   // Idle time is not counted, so a quiet bus never trips the watchdog
   assign wdFire = (q.phase != PH_IDLE)
                 & (q.wdCnt == WD_W'(LOCKUP_CYCLES - 1));

   assign pushWord.regAddr = q.startAddr;
   assign pushWord.data    = q.rxShift;

   // Open drain: the pad only ever pulls low
   assign serialDataPinOut = 1'b0;
   assign serialDataPinOe  = q.sdaOe;
   assign rdAddr           = q.rdPtr;
   assign busBusy          = (q.phase != PH_IDLE);

   always_comb begin
      d = q;
      pushValid = 1'b0;

      // Two-stage synchronisers on every pin
      d.sclMeta   = serialClockPin;
      d.sclSync   = q.sclMeta;
      d.sclLast   = q.sclSync;
      d.sdaMeta   = serialDataPinIn;
      d.sdaSync   = q.sdaMeta;
      d.sdaLast   = q.sdaSync;
      d.strapMeta = {addressBit1StrapPin, addressBit0StrapPin};
      d.strapSync = q.strapMeta;

      if (sclFall) begin
         d.sclFell = 1'b1;
      end

      if (q.phase == PH_IDLE || sclRise || sclFall) begin
         d.wdCnt = '0;
      end else begin
         d.wdCnt = q.wdCnt + 1'b1;
      end

      if (startDet) begin
         // Also serves as repeated start from any phase
         d.phase   = PH_ADDR;
         d.bitCnt  = '0;
         d.sdaOe   = 1'b0;
         d.sclFell = 1'b0;
      end else if (stopDet && q.sclFell) begin
         d.phase = PH_IDLE;
         d.sdaOe = 1'b0;
      end else if (wdFire) begin
         d.phase  = PH_IDLE;
         d.sdaOe  = 1'b0;
         d.bitCnt = '0;
      end else if (sclRise) begin
         if (q.phase == PH_ADDR || q.phase == PH_REG || q.phase == PH_DATA) begin
            d.rxShift = {q.rxShift[6:0], q.sdaSync};
         end
         if (q.phase == PH_ADDR || q.phase == PH_REG || q.phase == PH_DATA
             || q.phase == PH_RD_BYTE) begin
            if (!byteDone) begin
               d.bitCnt = q.bitCnt + 4'h1;
            end
         end
         if (q.phase == PH_RD_ACK) begin
            d.hostAck = ~q.sdaSync;
         end
      end else if (sclFall) begin
         case (q.phase)
            PH_ADDR: begin
               if (byteDone) begin
                  d.bitCnt = '0;
                  if (addrMatch) begin
                     d.phase = PH_ADDR_ACK;
                     d.sdaOe = 1'b1;
                     if (q.rxShift[0]) begin
                        d.rdPtr = q.startAddr;
                     end
                  end else begin
                     d.phase = PH_IGNORE;
                  end
               end
            end
            PH_ADDR_ACK: begin
               if (q.rxShift[0]) begin
                  d.phase   = PH_RD_BYTE;
                  d.txShift = rdData;
                  d.sdaOe   = ~rdData[7];
               end else begin
                  d.phase = PH_REG;
                  d.sdaOe = 1'b0;
               end
            end
            PH_REG: begin
               if (byteDone) begin
                  d.bitCnt    = '0;
                  d.startAddr = q.rxShift;
                  d.phase     = PH_REG_ACK;
                  d.sdaOe     = 1'b1;
               end
            end
            PH_REG_ACK: begin
               d.phase = PH_DATA;
               d.sdaOe = 1'b0;
            end
            PH_DATA: begin
               if (byteDone) begin
                  d.bitCnt = '0;
                  // A full buffer costs the controller a not-acknowledge, not a lost word
                  if (pushReady) begin
                     pushValid = 1'b1;
                     d.phase   = PH_DATA_ACK;
                     d.sdaOe   = 1'b1;
                  end else begin
                     d.phase = PH_IGNORE;
                  end
               end
            end
            PH_DATA_ACK: begin
               // One data byte per write; further bytes are not acknowledged
               d.phase = PH_IGNORE;
               d.sdaOe = 1'b0;
            end
            PH_RD_BYTE: begin
               if (byteDone) begin
                  d.bitCnt = '0;
                  d.phase  = PH_RD_ACK;
                  d.sdaOe  = 1'b0;
                  d.rdPtr  = q.rdPtr + 8'h01;
               end else begin
                  d.txShift = {q.txShift[6:0], 1'b0};
                  d.sdaOe   = ~q.txShift[6];
               end
            end
            PH_RD_ACK: begin
               if (q.hostAck) begin
                  d.phase   = PH_RD_BYTE;
                  d.txShift = rdData;
                  d.sdaOe   = ~rdData[7];
               end else begin
                  d.phase = PH_IGNORE;
                  d.sdaOe = 1'b0;
               end
            end
            default: begin
               d.sdaOe = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         q           <= '0;
         q.phase     <= PH_IDLE;
         // Line stages start at the idle level, so leaving reset brings no false edge
         {q.sclMeta, q.sclSync, q.sclLast} <= '1;
         {q.sdaMeta, q.sdaSync, q.sdaLast} <= '1;
         q.startAddr <= REG_RESET;
         q.rdPtr     <= REG_RESET;
      end else begin
         q <= d;
      end
   end

   sitp_wr_buf u_wr_buf (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .inValid  (pushValid),
      .inReady  (pushReady),
      .inWord   (pushWord),
      .outValid (wrValid),
      .outReady (wrReady),
      .outWord  (wrWord)
   );

   default clocking cb @(posedge clk);
   endclocking

   default disable iff (sys_rst);

   start_enter_a: assert property (
      startDet |=> (q.phase == PH_ADDR) && !q.sdaOe && (q.bitCnt == 4'h0)
   ) else $error("start did not enter address phase");

   stop_idle_a: assert property (
      (stopDet && q.sclFell && !startDet) |=> (q.phase == PH_IDLE) && !q.sdaOe
   ) else $error("stop did not return to idle");

   stop_early_a: assert property (
      (stopDet && !q.sclFell && !wdFire && q.phase != PH_IDLE)
      |=> (q.phase == $past(q.phase))
   ) else $error("stop right after start was recognised");

   drive_phase_a: assert property (
      q.sdaOe |-> (q.phase inside {PH_ADDR_ACK, PH_REG_ACK, PH_DATA_ACK, PH_RD_BYTE})
   ) else $error("data line pulled low outside a drive phase");

   ack_hold_a: assert property (
      (q.phase == PH_ADDR_ACK && q.sdaOe && sclRise) |=> q.sdaOe [*2]
   ) else $error("address acknowledge released during high phase");

   foreign_addr_a: assert property (
      (q.phase == PH_ADDR && sclFall && byteDone && !addrMatch && !startDet
       && !stopDet && !wdFire)
      |=> (q.phase == PH_IGNORE) && !q.sdaOe
   ) else $error("foreign address was acknowledged");

   own_addr_a: assert property (
      (q.phase == PH_ADDR && sclFall && byteDone && !startDet && !stopDet && !wdFire
       && q.rxShift[7:1] == {ADDR_FIXED, q.strapSync})
      |=> (q.phase == PH_ADDR_ACK) && q.sdaOe
   ) else $error("own address was not acknowledged");

   read_start_a: assert property (
      (q.phase == PH_ADDR && sclFall && byteDone && addrMatch && q.rxShift[0]
       && !startDet && !stopDet && !wdFire)
      |=> (q.rdPtr == $past(q.startAddr))
   ) else $error("read did not start at last written address");

   read_incr_a: assert property (
      (q.phase == PH_RD_BYTE && sclFall && byteDone && !startDet && !stopDet && !wdFire)
      |=> (q.rdPtr == $past(q.rdPtr) + 8'h01) && (q.phase == PH_RD_ACK)
   ) else $error("read address did not advance");

   nack_release_a: assert property (
      (q.phase == PH_RD_ACK && sclFall && !q.hostAck && !startDet && !stopDet && !wdFire)
      |=> (q.phase == PH_IGNORE) && !q.sdaOe
   ) else $error("not-acknowledge did not release the line");

   reset_addr_a: assert property (
      $fell(sys_rst) |-> (q.startAddr == REG_RESET) && (q.rdPtr == REG_RESET)
   ) else $error("read start address not cleared by reset");

   watchdog_a: assert property (
      (wdFire && !startDet && !(stopDet && q.sclFell))
      |=> (q.phase == PH_IDLE) && !q.sdaOe
   ) else $error("watchdog did not reset the port");

   write_push_a: assert property (
      (pushValid && pushReady) |=> wrValid
   ) else $error("written byte never reached the buffer output");

   reg_capture_a: assert property (
      (q.phase == PH_REG && sclFall && byteDone && !startDet && !stopDet && !wdFire)
      |=> (q.startAddr == $past(q.rxShift)) && (q.phase == PH_REG_ACK) && q.sdaOe
   ) else $error("register address byte not captured and acknowledged");

   full_nack_a: assert property (
      (q.phase == PH_DATA && sclFall && byteDone && !pushReady && !startDet && !stopDet
       && !wdFire) |=> (q.phase == PH_IGNORE) && !q.sdaOe
   ) else $error("data byte acknowledged although the buffer was full");

   data_once_a: assert property (
      (q.phase == PH_DATA_ACK && sclFall && !startDet && !stopDet && !wdFire)
      |=> (q.phase == PH_IGNORE) && !q.sdaOe
   ) else $error("second data byte of a write was accepted");

   read_load_a: assert property (
      (q.phase == PH_ADDR_ACK && sclFall && q.rxShift[0] && !startDet && !stopDet && !wdFire)
      |=> (q.phase == PH_RD_BYTE) && (q.sdaOe == !$past(rdData[7]))
   ) else $error("read did not begin with the top bit of the register byte");

   tx_shift_a: assert property (
      (q.phase == PH_RD_BYTE && sclFall && !byteDone && !startDet && !stopDet && !wdFire)
      |=> (q.sdaOe == !$past(q.txShift[6]))
   ) else $error("read bit not driven from the shift register");

   ignore_hold_a: assert property (
      (q.phase == PH_IGNORE && !startDet && !stopDet && !wdFire) |=> (q.phase == PH_IGNORE)
   ) else $error("ignored transfer left the ignore phase without a start");

endmodule

`default_nettype wire

// ---- verification/sitp_ctrl_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module sitp_ctrl_model
#(
   parameter int QTR = 2
)
(
   input  wire logic clk,
   input  wire logic sdaWire,
   output logic      sclPin,
   output logic      sdaLow
);

   // Both lines released at power-up, so the pull-ups hold the bus idle
   initial begin
      sclPin = 1'b1;
      sdaLow = 1'b0;
   end

   // A quarter of 2 clk gives a 200 ns bit; each line phase still spans 4 clk
   task automatic quarter();
      repeat (QTR) @(posedge clk);
   endtask

   task automatic startCond();
      sdaLow <= 1'b0;
      quarter();
      sclPin <= 1'b1;
      quarter();
      sdaLow <= 1'b1;
      quarter();
   endtask

   task automatic start();
      startCond();
      sclPin <= 1'b0;
      quarter();
   endtask

   task automatic stop();
      sdaLow <= 1'b1;
      quarter();
      sclPin <= 1'b1;
      quarter();
      sdaLow <= 1'b0;
      quarter();
   endtask

   // Only called where a scenario wants the unsupported start-stop pair
   task automatic bareStop();
      sdaLow <= 1'b0;
      quarter();
   endtask

   task automatic bitIo(input logic b, output logic r);
      sdaLow <= ~b;
      quarter();
      sclPin <= 1'b1;
      quarter();
      r = sdaWire;
      quarter();
      sclPin <= 1'b0;
      quarter();
   endtask

   // MSB first; a one releases the line, ackOut is the ninth bit
   task automatic byteIo(input logic [7:0] d, input logic ackOut,
                         output logic [7:0] q, output logic ackIn);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bitIo(d[i], r);
         q[i] = r;
      end
      bitIo(ackOut, ackIn);
   endtask

endmodule

`default_nettype wire

// ---- verification/sitp_target_bench.sv ----
`timescale 1ns/1ps
`default_nettype none

module sitp_target_bench;
   import sitp_pkg::*;

   localparam int WD = 200;

   logic          clk = 1'b0;
   logic          sys_rst = 1'b1;
   logic [1:0]    strap = 2'h0;
   logic          wrReady = 1'b0;
   logic [7:0]    rdData;
   logic [7:0]    rdAddr;
   logic          sclPin;
   logic          sdaLow;
   logic          sdaOut;
   logic          sdaOe;
   logic          wrValid;
   logic          busBusy;
   logic          sdaWire;
   sitp_wr_word_t wrWord;
   int            failCount = 0;
   int            testsRun = 0;
   logic [7:0]    q;
   logic          a;

   always #12.5 clk = ~clk;

   // Pull-up wins unless some party pulls low
   assign sdaWire = ~((sdaOe & ~sdaOut) | sdaLow);
   assign rdData = rdAddr ^ 8'h5A;

   sitp_target #(.LOCKUP_CYCLES(WD)) dut_u (
      .clk(clk), .sys_rst(sys_rst), .serialClockPin(sclPin),
      .serialDataPinIn(sdaWire), .serialDataPinOut(sdaOut), .serialDataPinOe(sdaOe),
      .addressBit0StrapPin(strap[0]), .addressBit1StrapPin(strap[1]),
      .rdAddr(rdAddr), .rdData(rdData), .wrValid(wrValid), .wrReady(wrReady),
      .wrWord(wrWord), .busBusy(busBusy));

   sitp_ctrl_model ctl_u (.clk(clk), .sdaWire(sdaWire), .sclPin(sclPin), .sdaLow(sdaLow));

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      testsRun++;
      if (got !== exp) begin
         failCount++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", testsRun, failCount);
      if (failCount == 0 && testsRun > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   function automatic logic [7:0] devAddr(input logic [1:0] s, input logic rw);
      return {ADDR_FIXED, s, rw};
   endfunction

   task automatic xfer(input logic [7:0] d, input logic ackOut, input logic ackExp,
                       input string what);
      ctl_u.byteIo(d, ackOut, q, a);
      chk(what, {15'h0, ackExp}, {15'h0, a});
   endtask

   task automatic settle();
      repeat (2) @(posedge clk);
      @(negedge clk);
   endtask

   task automatic testIdle();
      chk("busy", 16'h0, {15'h0, busBusy});
      chk("rdAddr", 16'h0, {8'h0, rdAddr});
      ctl_u.start();
      xfer(devAddr(strap, 1'b1), 1'b1, 1'b0, "raddr");
      ctl_u.byteIo(8'hFF, 1'b1, q, a);
      chk("first", {8'h0, REG_RESET ^ 8'h5A}, {8'h0, q});
      ctl_u.stop();
      $display("done idle");
   endtask

   task automatic testStraps();
      for (int s = 0; s < 4; s++) begin
         strap <= 2'(s);
         ctl_u.start();
         settle();
         chk("busy", 16'h1, {15'h0, busBusy});
         @(posedge clk);
         xfer(devAddr(2'(s), 1'b0), 1'b1, 1'b0, "own");
         ctl_u.stop();
         settle();
         chk("idle", 16'h0, {15'h0, busBusy});
         @(posedge clk);
         ctl_u.start();
         xfer(devAddr(2'(s) ^ 2'h1, 1'b0), 1'b1, 1'b1, "foreign");
         xfer(8'h00, 1'b1, 1'b1, "ignored");
         ctl_u.stop();
      end
      ctl_u.start();
      xfer(8'hF0, 1'b1, 1'b1, "tenbit");
      ctl_u.stop();
      $display("done straps");
   endtask

   // Consumer stalls, so the third data byte meets a full buffer
   task automatic testBuffer();
      for (int k = 0; k < 3; k++) begin
         ctl_u.start();
         xfer(devAddr(strap, 1'b0), 1'b1, 1'b0, "waddr");
         xfer(8'h40 + 8'(k), 1'b1, 1'b0, "reg");
         xfer(8'hC0 + 8'(k), 1'b1, k == 2, "data");
         ctl_u.stop();
      end
      @(posedge clk);
      wrReady <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         @(negedge clk);
         chk("valid", 16'h1, {15'h0, wrValid});
         chk("word", {8'h40 + 8'(k), 8'hC0 + 8'(k)}, wrWord);
         @(posedge clk);
      end
      @(negedge clk);
      chk("empty", 16'h0, {15'h0, wrValid});
      // A second data byte in one write must be refused and must not reach the buffer
      @(posedge clk);
      wrReady <= 1'b0;
      ctl_u.start();
      xfer(devAddr(strap, 1'b0), 1'b1, 1'b0, "waddr");
      xfer(8'h10, 1'b1, 1'b0, "reg");
      xfer(8'h33, 1'b1, 1'b0, "data");
      xfer(8'h44, 1'b1, 1'b1, "extra");
      ctl_u.stop();
      settle();
      chk("valid", 16'h1, {15'h0, wrValid});
      chk("word", 16'h1033, wrWord);
      @(posedge clk);
      wrReady <= 1'b1;
      $display("done buffer");
   endtask

   // Start near the top so the pointer wraps inside one transfer
   task automatic testRead();
      ctl_u.start();
      xfer(devAddr(strap, 1'b0), 1'b1, 1'b0, "waddr");
      xfer(8'hFE, 1'b1, 1'b0, "reg");
      ctl_u.start();
      xfer(devAddr(strap, 1'b1), 1'b1, 1'b0, "raddr");
      for (int k = 0; k < 3; k++) begin
         ctl_u.byteIo(8'hFF, k == 2, q, a);
         chk("byte", {8'h0, (8'hFE + 8'(k)) ^ 8'h5A}, {8'h0, q});
      end
      settle();
      chk("release", 16'h0, {15'h0, sdaOe});
      chk("lowOnly", 16'h0, {15'h0, sdaOut});
      @(posedge clk);
      ctl_u.stop();
      ctl_u.start();
      xfer(devAddr(strap, 1'b1), 1'b1, 1'b0, "raddr");
      ctl_u.byteIo(8'hFF, 1'b1, q, a);
      chk("again", {8'h0, 8'hFE ^ 8'h5A}, {8'h0, q});
      ctl_u.stop();
      $display("done read");
   endtask

   // The ignored stop leaves the port busy with no clock, which the watchdog must clear
   task automatic testLock();
      ctl_u.startCond();
      ctl_u.bareStop();
      settle();
      chk("busy", 16'h1, {15'h0, busBusy});
      repeat (WD - 40) @(posedge clk);
      @(negedge clk);
      chk("held", 16'h1, {15'h0, busBusy});
      repeat (60) @(posedge clk);
      @(negedge clk);
      chk("lockup", 16'h0, {15'h0, busBusy});
      $display("done lock");
   endtask

   initial begin
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (6) @(posedge clk);
      testIdle();
      testStraps();
      testBuffer();
      testRead();
      testLock();
      conclude();
   end

   // About 40 bytes at 72 clk each plus the lockup wait; ample margin on top
   initial begin
      repeat (40000) @(posedge clk);
      failCount++;
      conclude();
   end

endmodule

`default_nettype wire
